// >>> test/cidr_top_checker.sv
/*
  Port assertions for the identification register bank.
  Assumes a master that holds each request until it samples ack.
*/
`timescale 1ns/1ps
module cidr_top_checker (
  input wire logic               I_REF_CLK,
  input wire logic               I_RSTN,
  input wire logic               I_EXT_ACCESS_SEL,
  input wire cidr_pkg::cidr_rev_t I_SILICON_REV,
  input wire logic               I_WB_CYC,
  input wire logic               I_WB_STB,
  input wire logic               I_WB_WE,
  input wire cidr_pkg::cidr_bus_t I_WB_ADR,
  input wire cidr_pkg::cidr_bus_t O_WB_DAT,
  input wire logic               O_WB_ACK,
  input wire logic               O_INIT_DONE
);
  import cidr_pkg::*;
  localparam cidr_bus_t A_PROG = 32'h0003C1E0;
  localparam cidr_bus_t A_MEM  = 32'h0003C1E8;
  localparam cidr_bus_t A_PART = 32'h0003C1F0;
  logic rd_ack;
  assign rd_ack = O_WB_ACK && !I_WB_WE;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  chk_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack missing");
  chk_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack too long");
  chk_ack_cause: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
    else $error("ack without request");
  chk_high_zero: assert property (O_WB_ACK |-> O_WB_DAT[31:16] == 16'h0000)
    else $error("upper half not zero");
  chk_mem_final: assert property (rd_ack && I_WB_ADR == A_MEM && $past(O_INIT_DONE) |-> O_WB_DAT[15:0] == 16'h3040)
    else $error("memory word wrong");
  chk_mem_busy: assert property (rd_ack && I_WB_ADR == A_MEM && !$past(O_INIT_DONE) |-> O_WB_DAT[15:14] == 2'b11)
    else $error("busy bits low");
  chk_prog_word: assert property (rd_ack && I_WB_ADR == A_PROG |-> O_WB_DAT[15:0] == 16'h0040)
    else $error("voltage word wrong");
  chk_part_rev: assert property (rd_ack && I_WB_ADR == A_PART |-> O_WB_DAT[3:0] == $past(I_SILICON_REV))
    else $error("revision digit wrong");
  chk_write_ro: assert property (O_WB_ACK && I_WB_WE |-> O_WB_DAT == 32'h00000000)
    else $error("write answer carries data");
  chk_fast_boot: assert property ($rose(I_RSTN) && I_EXT_ACCESS_SEL |=> O_INIT_DONE)
    else $error("internal boot not ready");
  chk_slow_boot: assert property ($rose(I_RSTN) && !I_EXT_ACCESS_SEL |=> !O_INIT_DONE [*8])
    else $error("external boot ready at once");
  cover property (rd_ack && I_WB_ADR == A_MEM && $past(O_INIT_DONE));
  cover property ($rose(I_RSTN) && !I_EXT_ACCESS_SEL);
  cover property (O_WB_ACK && I_WB_WE);
endmodule // cidr_top_checker

bind cidr_top cidr_top_checker u_cidr_top_checker (
  .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_EXT_ACCESS_SEL(I_EXT_ACCESS_SEL),
  .I_SILICON_REV(I_SILICON_REV), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
  .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_INIT_DONE(O_INIT_DONE)
);

// >>> test/testbench.sv
/*
  Self-checking bench for the identification register bank.
  Assumes the bank answers each Wishbone request with a one-cycle ack.
*/
`timescale 1ns/1ps
module testbench;
  import cidr_pkg::*;
  logic      I_REF_CLK, I_RSTN, I_EXT_ACCESS_SEL, I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK, O_INIT_DONE;
  cidr_rev_t I_SILICON_REV;
  cidr_sel_t I_WB_SEL;
  cidr_bus_t I_WB_ADR, I_WB_DAT, O_WB_DAT;
  cidr_word_t rd;
  int n_mismatch, samples_checked, i;
  cidr_bus_t  adr[4] = '{32'h0003C1F8, 32'h0003C1F0, 32'h0003C1E8, 32'h0003C1E0};
  cidr_word_t fin[4] = '{16'h2A55, 16'h7E29, 16'h3040, 16'h0040};
  cidr_word_t prv[4] = '{16'h5A01, 16'h7E29, 16'hF040, 16'h0040};
  cidr_top u_cidr_top (.I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_EXT_ACCESS_SEL(I_EXT_ACCESS_SEL),
    .I_SILICON_REV(I_SILICON_REV), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
    .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT),
    .O_WB_ACK(O_WB_ACK), .O_INIT_DONE(O_INIT_DONE));
  initial begin
    I_REF_CLK = 1'b0;
    forever #12.5 I_REF_CLK = ~I_REF_CLK;
  end
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input cidr_word_t e, input cidr_word_t g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Entered just after a rising edge; leaves the bus idle for one cycle
  task automatic wb(input logic we, input cidr_bus_t a, input cidr_word_t d);
    I_WB_CYC <= 1'b1;
    I_WB_STB <= 1'b1;
    I_WB_WE  <= we;
    I_WB_ADR <= a;
    I_WB_SEL <= 4'hF;
    I_WB_DAT <= {16'h0000, d};
    // No limit here: the watchdog ends a wait that never sees ack
    do begin
      @(posedge I_REF_CLK);
    end while (O_WB_ACK !== 1'b1);
    rd = O_WB_DAT[15:0];
    I_WB_CYC <= 1'b0;
    I_WB_STB <= 1'b0;
    @(posedge I_REF_CLK);
  endtask
  task automatic rdc(input string n, input cidr_bus_t a, input cidr_word_t e);
    wb(1'b0, a, 16'h0000);
    chk(n, e, rd);
  endtask
  task automatic boot(input logic ext);
    I_RSTN <= 1'b0;
    I_EXT_ACCESS_SEL <= ext;
    repeat (2) @(posedge I_REF_CLK);
    I_RSTN <= 1'b1;
    repeat (2) @(posedge I_REF_CLK);
  endtask
  initial begin
    #(25 * 30000);
    n_mismatch++;
    test_done();
  end
  initial begin
    {I_RSTN, I_EXT_ACCESS_SEL, I_WB_CYC, I_WB_STB, I_WB_WE} = 5'h00;
    {I_WB_ADR, I_WB_DAT} = 64'h0;
    I_WB_SEL = 4'hF;
    I_SILICON_REV = 4'h9;
    n_mismatch = 0;
    samples_checked = 0;
    boot(1'b1);
    chk("done", 16'h0001, {15'h0000, O_INIT_DONE});
    rdc("control", 32'h0003C1D8, 16'h0002);
    for (i = 0; i < 4; i++) rdc("final", adr[i], fin[i]);
    rdc("unmapped", 32'h00000100, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, adr[i], ~fin[i]);
      rdc("read only", adr[i], fin[i]);
    end
    $display("test internal boot done");
    boot(1'b0);
    for (i = 0; i < 4; i++) rdc("default", adr[i], prv[i]);
    i = 0;
    do begin
      wb(1'b0, 32'h0003C1E8, 16'h0000);
      i++;
    end while (rd[15:14] !== 2'b00 && i < 2000);
    chk("busy bits", 16'h0000, {14'h0000, rd[15:14]});
    for (i = 0; i < 4; i++) rdc("switched", adr[i], fin[i]);
    rdc("control", 32'h0003C1D8, 16'h0006);
    $display("test external boot done");
    wb(1'b1, 32'h0003C1D8, 16'h0001);
    chk("restart", 16'h0000, {15'h0000, O_INIT_DONE});
    rdc("restart mem", 32'h0003C1E8, 16'hF040);
    $display("test restart done");
    test_done();
  end
endmodule // testbench

// >>> verilog/cidr_defs.svh
/*
  Constants of the chip identification register bank: register indices,
  field positions, default and final values, initialisation timing.
  Assumes a 40 MHz system clock and a 32-bit classic Wishbone bus.
*/
`ifndef CIDR_DEFS_SVH
`define CIDR_DEFS_SVH

// Register word indices; byte address is four times the index
`define CIDR_IDX_PROG          16'hF078
`define CIDR_IDX_MEM           16'hF07A
`define CIDR_IDX_PART          16'hF07C
`define CIDR_IDX_MAKER         16'hF07E
`define CIDR_IDX_CTRL          16'hF076

// Field positions of memory_type_size_id
`define CIDR_MEM_TYPE_MSB      15
`define CIDR_MEM_TYPE_LSB      12
`define CIDR_MEM_SIZE_MSB      11
`define CIDR_MEM_SIZE_LSB      0
`define CIDR_MEM_BUSY_HI       15
`define CIDR_MEM_BUSY_LO       14

// Field positions of programming_voltage_id
`define CIDR_VPP_MSB           15
`define CIDR_VPP_LSB           8
`define CIDR_VDD_MSB           7
`define CIDR_VDD_LSB           0

// Field positions of part_revision_word
`define CIDR_REV_MSB           3
`define CIDR_REV_LSB           0

// Control register bits
`define CIDR_CTRL_RESTART      0
`define CIDR_CTRL_DONE         1
`define CIDR_CTRL_EXT_BOOT     2

// Memory type encodings
`define CIDR_MTYPE_NONE        4'h0
`define CIDR_MTYPE_MROM        4'h1
`define CIDR_MTYPE_STD_FLASH   4'h2
`define CIDR_MTYPE_HP_FLASH    4'h3

// Final field values
`define CIDR_CAPACITY_KB       256
`define CIDR_KB_PER_UNIT       4
`define CIDR_PROG_VDD_5V       8'h40
`define CIDR_PROG_VPP_NONE     8'h00

// Provisional values shown before flash initialisation ends (arbitrary)
`define CIDR_PROV_MAKER        16'h5A01
`define CIDR_PROV_PART         16'h7E20
`define CIDR_PROV_MEM          16'hF040
`define CIDR_PROV_PROG         16'h0040

// Final identity values (arbitrary, not any real part)
`define CIDR_FINAL_MAKER       16'h2A55
`define CIDR_FINAL_PART_HI     12'h7E2

// Flash initialisation time after an external boot
`define CIDR_CLK_MHZ           40
`define CIDR_INIT_TIME_NS      100000
`define CIDR_INIT_CYCLES       ((`CIDR_INIT_TIME_NS * `CIDR_CLK_MHZ) / 1000)
`define CIDR_CNT_W             12

`endif

// >>> verilog/cidr_init_seq.sv
/*
  Flash initialisation sequencer: decides when identification values turn final.
  Assumes the boot-select level is stable around the release of reset.
*/
`timescale 1ns/1ps
`include "cidr_defs.svh"

module cidr_init_seq (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_ext_sel,
  input  wire logic i_restart,
  output logic      o_done,
  output logic      o_ext_boot
);
  import cidr_pkg::*;

  localparam logic [`CIDR_CNT_W-1:0] INIT_LAST = `CIDR_CNT_W'(`CIDR_INIT_CYCLES - 1);

  cidr_state_e             state_reg, state_next;
  logic [`CIDR_CNT_W-1:0]  cnt_reg, cnt_next;
  logic                    ext_reg, ext_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    ext_next   = ext_reg;
    case (state_reg)
      CIDR_ST_CAPTURE: begin
        // Boot select caught on the first edge after reset release
        ext_next = ~i_ext_sel;
        cnt_next = '0;
        if (i_ext_sel) begin
          state_next = CIDR_ST_DONE; // [R7]
        end else begin
          state_next = CIDR_ST_BUSY; // [R8]
        end
      end
      CIDR_ST_BUSY: begin
        if (cnt_reg == INIT_LAST) begin
          state_next = CIDR_ST_DONE;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      CIDR_ST_DONE: begin
        if (i_restart) begin
          cnt_next   = '0;
          state_next = CIDR_ST_BUSY;
        end
      end
      default: begin
        state_next = CIDR_ST_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= CIDR_ST_CAPTURE;
      cnt_reg   <= '0;
      ext_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      ext_reg   <= ext_next;
    end
  end

  assign o_done     = (state_reg == CIDR_ST_DONE);
  assign o_ext_boot = ext_reg;
endmodule // cidr_init_seq

// >>> verilog/cidr_pkg.sv
/*
  Types of the chip identification register bank.
  Assumes cidr_defs.svh for all numeric constants.
*/
package cidr_pkg;
  typedef logic [15:0] cidr_word_t;
  typedef logic [31:0] cidr_bus_t;
  typedef logic [3:0]  cidr_sel_t;
  typedef logic [3:0]  cidr_rev_t;
  typedef enum logic [1:0] {
    CIDR_ST_CAPTURE,
    CIDR_ST_BUSY,
    CIDR_ST_DONE
  } cidr_state_e;
endpackage

// >>> verilog/cidr_top.sv
/*
  Chip identification register bank behind a classic Wishbone slave.
  Maker, part, memory and programming-voltage words, read-only, with
  provisional values until flash initialisation ends, plus one control word.
  Assumes a 40 MHz clock, asynchronous active-low reset and a master that
  holds each request until it sees ack. The boot-select pin must be steady
  around reset release; software that boots externally polls the busy bits
  before it trusts any identification word.
*/
// Operation
// [R1] The capacity field holds the memory size in kilobytes divided by four.
// [R2] The memory type field reads 0h none, 1h mask ROM, 2h standard flash, 3h fast flash; 4h to Fh reserved.
// [R3] The supply field reads 40h, meaning 20 times the value over 256 volts, five volts.
// [R4] The external programming-voltage field always reads 00h.
// [R5] Writes to any identification word leave it unchanged.
// [R6] Identification words are only guaranteed correct after flash initialisation ends.
// [R7] With the external-access select pin high at reset, initialisation is complete at once.
// [R8] With that pin low at reset, initialisation is still running when execution begins.
// [R9] Bits 15 and 14 of the memory word read low once initialisation ends; software polls them.
// [R10] Before initialisation ends each word reads a fixed default, the part word tracking revision.
// [R11] Four identification words sit in the extended register space: maker, part, memory, voltage.
// [R12] All words switch from default to final values in the same clock cycle.
`timescale 1ns/1ps
`include "cidr_defs.svh"

module cidr_top (
  input  wire logic               I_REF_CLK,
  input  wire logic               I_RSTN,
  // Boot select, high for internal boot
  input  wire logic               I_EXT_ACCESS_SEL,
  // Silicon revision digit
  input  wire cidr_pkg::cidr_rev_t I_SILICON_REV,
  // Wishbone classic slave
  input  wire logic               I_WB_CYC,
  input  wire logic               I_WB_STB,
  input  wire logic               I_WB_WE,
  input  wire cidr_pkg::cidr_bus_t I_WB_ADR,
  input  wire cidr_pkg::cidr_sel_t I_WB_SEL,
  input  wire cidr_pkg::cidr_bus_t I_WB_DAT,
  output cidr_pkg::cidr_bus_t     O_WB_DAT,
  output logic                    O_WB_ACK,
  // Initialisation finished, level
  output logic                    O_INIT_DONE
);
  import cidr_pkg::*;

  // Final field values
  localparam logic [11:0] MEM_SIZE_FINAL =
    12'(`CIDR_CAPACITY_KB / `CIDR_KB_PER_UNIT); // [R1]
  localparam logic [3:0]  MEM_TYPE_FINAL = `CIDR_MTYPE_HP_FLASH; // [R2]

  // Request decode
  logic        req;
  logic        word_hit;
  logic [15:0] index;
  logic        hit_maker;
  logic        hit_part;
  logic        hit_mem;
  logic        hit_prog;
  logic        hit_ctrl;

  // Bus answer state
  logic        ack_reg, ack_next;
  cidr_bus_t   dat_reg, dat_next;

  // Control state
  logic        restart_reg, restart_next;

  // Initialisation status
  logic        init_done;
  logic        ext_boot;
  logic        use_final;

  // Named fields of the final words
  logic [3:0]  mem_type_field;
  logic [11:0] internal_capacity_field;
  logic [7:0]  program_supply_level_field;
  logic [7:0]  external_program_voltage_field;
  logic [11:0] part_number_field;
  cidr_rev_t   revision_field;

  // Request phases
  logic        take;
  logic        rd_take;
  logic        wr_take;
  logic        ctrl_wr;
  logic        id_wr;
  logic        hit_any;
  logic [4:0]  hit_vec;

  // Current word values
  cidr_word_t  maker_word;
  cidr_word_t  part_word;
  cidr_word_t  mem_word;
  cidr_word_t  prog_word;
  cidr_word_t  ctrl_word;
  cidr_word_t  read_word;

  cidr_word_t  part_prov;
  cidr_word_t  part_final;
  cidr_word_t  mem_final;
  cidr_word_t  prog_final;
  cidr_word_t  maker_final;
  cidr_word_t  maker_prov;
  cidr_word_t  mem_prov;
  cidr_word_t  prog_prov;

  cidr_init_seq u_init (
    .i_clk      (I_REF_CLK),
    .i_rstn     (I_RSTN),
    .i_ext_sel  (I_EXT_ACCESS_SEL),
    .i_restart  (restart_reg),
    .o_done     (init_done),
    .o_ext_boot (ext_boot)
  );

  // Address decode: word aligned, index in address bits 17:2, bits 31:18 zero
  assign req      = I_WB_CYC & I_WB_STB;
  assign word_hit = (I_WB_ADR[31:18] == 14'h0) & (I_WB_ADR[1:0] == 2'h0);
  assign index    = I_WB_ADR[17:2];

  // Decode into one flag per word; the flags are mutually exclusive
  always_comb begin
    hit_maker = 1'b0;
    hit_part  = 1'b0;
    hit_mem   = 1'b0;
    hit_prog  = 1'b0;
    hit_ctrl  = 1'b0;
    if (word_hit) begin
      case (index)
        `CIDR_IDX_MAKER: begin
          hit_maker = 1'b1; // [R11]
        end
        `CIDR_IDX_PART: begin
          hit_part = 1'b1;  // [R11]
        end
        `CIDR_IDX_MEM: begin
          hit_mem = 1'b1;   // [R11]
        end
        `CIDR_IDX_PROG: begin
          hit_prog = 1'b1;  // [R11]
        end
        `CIDR_IDX_CTRL: begin
          hit_ctrl = 1'b1;
        end
        default: begin
          hit_ctrl = 1'b0;
        end
      endcase
    end
  end

  assign hit_any = hit_maker | hit_part | hit_mem | hit_prog | hit_ctrl;
  assign hit_vec = {hit_ctrl, hit_prog, hit_mem, hit_part, hit_maker};

  // A request is taken on the edge that sees it with ack still low
  assign take    = req & ~ack_reg;
  assign rd_take = take & ~I_WB_WE;
  assign wr_take = take & I_WB_WE;
  // Only the lowest byte lane carries the restart bit
  assign ctrl_wr = wr_take & hit_ctrl & I_WB_SEL[0];
  assign id_wr   = wr_take & hit_any & ~hit_ctrl; // [R5]

  // Fields of the final words
  assign mem_type_field                 = MEM_TYPE_FINAL;      // [R2]
  assign internal_capacity_field        = MEM_SIZE_FINAL;      // [R1]
  assign program_supply_level_field     = `CIDR_PROG_VDD_5V;   // [R3]
  assign external_program_voltage_field = `CIDR_PROG_VPP_NONE; // [R4]
  assign part_number_field              = `CIDR_FINAL_PART_HI;
  // The revision digit is live in both the default and the final part word
  assign revision_field                 = I_SILICON_REV;       // [R10]

  // Final words
  assign maker_final = `CIDR_FINAL_MAKER;
  assign part_final  = {part_number_field, revision_field};

  // Busy bits 15:14 overlap the type field, so only types up to 3h read them
  // low once initialisation ends
  always_comb begin
    mem_final = '0;
    mem_final[`CIDR_MEM_TYPE_MSB:`CIDR_MEM_TYPE_LSB] = mem_type_field;          // [R2]
    mem_final[`CIDR_MEM_SIZE_MSB:`CIDR_MEM_SIZE_LSB] = internal_capacity_field; // [R1]
  end

  always_comb begin
    prog_final = '0;
    prog_final[`CIDR_VPP_MSB:`CIDR_VPP_LSB] = external_program_voltage_field; // [R4]
    prog_final[`CIDR_VDD_MSB:`CIDR_VDD_LSB] = program_supply_level_field;     // [R3]
  end

  // Default words
  assign maker_prov = `CIDR_PROV_MAKER; // [R10]
  assign mem_prov   = `CIDR_PROV_MEM;   // [R10]
  assign prog_prov  = `CIDR_PROV_PROG;  // [R10]

  // Provisional part word keeps the live revision digit
  always_comb begin
    part_prov = `CIDR_PROV_PART;
    part_prov[`CIDR_REV_MSB:`CIDR_REV_LSB] = revision_field; // [R10]
  end

  // One select for every word, so no read can see a mix of old and new
  assign use_final = init_done; // [R12]

  always_comb begin
    if (use_final) begin
      maker_word = maker_final;
      part_word  = part_final;
      mem_word   = mem_final;  // [R9]
      prog_word  = prog_final;
    end else begin // [R6]
      maker_word = maker_prov;
      part_word  = part_prov;
      mem_word   = mem_prov;
      prog_word  = prog_prov;
    end
  end

  always_comb begin
    ctrl_word = '0;
    ctrl_word[`CIDR_CTRL_RESTART]  = restart_reg;
    ctrl_word[`CIDR_CTRL_DONE]     = init_done;
    ctrl_word[`CIDR_CTRL_EXT_BOOT] = ext_boot;
  end

  // Read multiplexer; unmapped or misaligned addresses read zero
  always_comb begin
    read_word = '0;
    if (hit_any) begin
      case (hit_vec)
        5'h01: begin
          read_word = maker_word;
        end
        5'h02: begin
          read_word = part_word;
        end
        5'h04: begin
          read_word = mem_word;
        end
        5'h08: begin
          read_word = prog_word;
        end
        5'h10: begin
          read_word = ctrl_word;
        end
        default: begin
          read_word = '0;
        end
      endcase
    end
  end

  // Bus answer: one wait state, ack for exactly one cycle per request.
  // Read data is captured when the request is taken and held until the
  // next answer, so the master still finds it at its ack edge.
  always_comb begin
    ack_next = 1'b0;
    dat_next = dat_reg;
    if (take) begin
      ack_next = 1'b1;
    end
    if (rd_take) begin
      dat_next = {16'h0000, read_word};
    end
    if (wr_take) begin
      // Write answers carry no data
      dat_next = '0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // Control writes: only the restart bit is writable. Identification
  // words have no storage, so a write to them is acked and dropped.
  always_comb begin
    restart_next = 1'b0;
    if (ctrl_wr) begin
      // Restart is only honoured once the current pass has ended
      restart_next = I_WB_DAT[`CIDR_CTRL_RESTART] & init_done;
    end
    if (id_wr) begin
      restart_next = 1'b0; // [R5]
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= restart_next;
    end
  end

  assign O_WB_ACK    = ack_reg;
  assign O_WB_DAT    = dat_reg;
  assign O_INIT_DONE = init_done;
endmodule // cidr_top
